// ---- tb/usb_out_endpoint_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "usb_out_map.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; $display("FAIL %0t got %h exp %h", $time, a, e); end end

module usb_out_endpoint_control_test
    import usb_out_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  dAddr = 8'h00, hAddr = 8'h00;
    logic        dRd   = 1'b0, dWr = 1'b0, hRd = 1'b0, hWr = 1'b0;
    logic [31:0] dWd   = 32'h0000_0000, hWd = 32'h0000_0000;
    logic [31:0] dQ, hQ;
    logic        dWait, hWait, irq;
    logic [15:0] rnd   = 16'h6b15;
    logic [7:0]  q, seed, bitE;
    logic [9:0]  len;
    logic [1:0]  e;
    int          failures = 0;
    int          n_compared = 0;

    usb_out_link_if link ();

    always #20 clock = ~clock;

    usb_out_endpoint_control #(.MAX_PKT(64)) usb_out_endpoint_control_inst (.clock(clock), .rst(rst),
        .link(link), .avs_address(dAddr), .avs_read(dRd), .avs_write(dWr), .avs_writedata(dWd),
        .avs_readdata(dQ), .avs_waitrequest(dWait), .irq(irq));
    // short frame keeps iso waits brief
    usb_out_host_end #(.FRAME_CYCLES(50)) usb_out_host_end_inst (.clock(clock), .rst(rst), .link(link),
        .avs_address(hAddr), .avs_writedata(hWd), .avs_read(hRd), .avs_write(hWr),
        .avs_readdata(hQ), .avs_waitrequest(hWait));
    usb_out_link_monitor usb_out_link_monitor_inst (.clock(clock), .rst(rst), .tokValid(link.tokValid),
        .tokEp(link.tokEp), .tokPid(link.tokPid), .dataValid(link.dataValid), .dataByte(link.dataByte),
        .pktEnd(link.pktEnd), .crcErr(link.crcErr), .hsValid(link.hsValid), .hsCode(link.hsCode));

    // ----------------------------------------
    // bus cycles and expectations
    // ----------------------------------------
    function automatic logic [7:0] exp_byte(input logic [7:0] s, input int i);
        return s + i[7:0];
    endfunction : exp_byte

    task automatic acc(input bit h, input bit w, input logic [5:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        if (h) begin
            hAddr <= {idx, 2'b00};
            hWr <= w;
            hRd <= !w;
            hWd <= {24'h00_0000, d};
        end else begin
            dAddr <= {idx, 2'b00};
            dWr <= w;
            dRd <= !w;
            dWd <= {24'h00_0000, d};
        end
        do begin
            @(posedge clock);
            n++;
        end while ((h ? hWait : dWait) !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        q = h ? hQ[7:0] : dQ[7:0];
        hWr <= 1'b0;
        hRd <= 1'b0;
        dWr <= 1'b0;
        dRd <= 1'b0;
    endtask : acc

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] ex);
        acc(1'b0, 1'b0, idx, 8'h00);
        `CHK(q, ex)
    endtask : rd_chk

    task automatic send(input logic [2:0] f, input logic [9:0] n);
        acc(1'b1, 1'b1, `HIDX_LEN, n[7:0]);
        acc(1'b1, 1'b1, `HIDX_SEED, seed);
        acc(1'b1, 1'b1, `HIDX_CMD, {3'h0, f, e});
        q = 8'h01;
        for (int i = 0; i < 60 && q[0]; i++) acc(1'b1, 1'b0, `HIDX_STATUS, 8'h00);
        `CHK(q[0], 1'b0)
    endtask : send

    task automatic pick();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        len = {4'h0, rnd[5:0]} + 10'h001;
        seed = rnd[15:8];
        e = 2'(rnd % 3 + 1);
        bitE = 8'h01 << (e - 1);
        acc(1'b0, 1'b1, `IDX_SELECT, {6'h00, e});
    endtask : pick

    task automatic end_sim();
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        end_sim();
    end

    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        rd_chk(`IDX_CTRL_STATUS, 8'h00);
        rd_chk(`IDX_CONFIG, 8'h00);
        acc(1'b0, 1'b1, `IDX_INT_MASK, 8'h07);
        for (int k = 1; k <= 3; k++) begin
            pick();
            e = 2'(k);
            acc(1'b0, 1'b1, `IDX_SELECT, {6'h00, e});
            send(3'b000, len);
            `CHK(q[3:2], HS_ACK)
            rd_chk(`IDX_CTRL_STATUS, 8'h03);
            `CHK(irq, 1'b1)
            rd_chk(`IDX_COUNT_LOW, len[7:0]);
            rd_chk(`IDX_COUNT_HIGH, {6'h00, len[9:8]});
            for (int i = 0; i < len; i++) rd_chk(`IDX_FIFO_DATA, exp_byte(seed, i));
            acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h00);
            acc(1'b0, 1'b1, `IDX_INT_STATUS, 8'h07);
            rd_chk(`IDX_CTRL_STATUS, 8'h00);
            `CHK(irq, 1'b0)
        end
        // damaged bulk packet: no handshake, nothing stored
        send(3'b010, len);
        `CHK(q[1], 1'b0)
        // repeated toggle on endpoint three: acked but dropped
        send(3'b000, len);
        `CHK(q[3:2], HS_ACK)
        rd_chk(`IDX_CTRL_STATUS, 8'h00);
        rd_chk(`IDX_INT_STATUS, 8'h00);
        pick();
        acc(1'b0, 1'b1, `IDX_CONFIG, 8'hbf);
        rd_chk(`IDX_CONFIG, 8'h80);
        acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h80);
        rd_chk(`IDX_CTRL_STATUS, 8'h00);
        send(3'b000, len);
        send(3'b001, 10'h040);
        rd_chk(`IDX_CTRL_STATUS, 8'h03);
        acc(1'b0, 1'b1, `IDX_INT_STATUS, 8'h07);
        // full bulk fifo: refused without an interrupt
        send(3'b000, len);
        `CHK(q[3:2], HS_NAK)
        rd_chk(`IDX_INT_STATUS, 8'h00);
        acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h00);
        rd_chk(`IDX_CTRL_STATUS, 8'h01);
        rd_chk(`IDX_INT_STATUS, bitE);
        rd_chk(`IDX_COUNT_LOW, 8'h40);
        // ready written as one so only the flush can drop the packet
        acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h11);
        rd_chk(`IDX_CTRL_STATUS, 8'h00);
        acc(1'b0, 1'b1, `IDX_CONFIG, 8'h00);
        acc(1'b0, 1'b1, `IDX_INT_STATUS, 8'h07);
        pick();
        acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h20);
        send(3'b000, len);
        `CHK(q[3:2], HS_STALL)
        rd_chk(`IDX_CTRL_STATUS, 8'h60);
        rd_chk(`IDX_INT_STATUS, bitE);
        acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h00);
        acc(1'b0, 1'b1, `IDX_INT_STATUS, 8'h07);
        rd_chk(`IDX_CTRL_STATUS, 8'h00);
        pick();
        acc(1'b0, 1'b1, `IDX_CONFIG, 8'h40);
        acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h20);
        send(3'b110, len);
        rd_chk(`IDX_CTRL_STATUS, 8'h2b);
        rd_chk(`IDX_INT_STATUS, bitE);
        acc(1'b0, 1'b1, `IDX_INT_STATUS, 8'h07);
        send(3'b100, len);
        rd_chk(`IDX_CTRL_STATUS, 8'h2f);
        rd_chk(`IDX_INT_STATUS, bitE);
        acc(1'b0, 1'b1, `IDX_CTRL_STATUS, 8'h00);
        rd_chk(`IDX_CTRL_STATUS, 8'h00);
        end_sim();
    end
endmodule : usb_out_endpoint_control_test

`default_nettype wire

// ---- tb/usb_out_link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module usb_out_link_monitor
    import usb_out_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       tokValid,
    input wire logic [3:0] tokEp,
    input wire logic       tokPid,
    input wire logic       dataValid,
    input wire logic [7:0] dataByte,
    input wire logic       pktEnd,
    input wire logic       crcErr,
    input wire logic       hsValid,
    input wire hs_t        hsCode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // packet steps
    // ----------------------------------------
    sequence bad_end_s; pktEnd && crcErr; endsequence
    sequence quiet_s; !tokValid [*2]; endsequence

    AST_HS_AFTER_END: assert property (hsValid |-> $past(pktEnd))
        else $error("handshake without a packet end before it");
    AST_HS_PULSE: assert property (hsValid |=> !hsValid)
        else $error("handshake longer than one cycle");
    AST_NO_HS_CRC: assert property (bad_end_s |=> !hsValid)
        else $error("handshake after a damaged packet");
    AST_HS_CODE: assert property (hsValid |-> hsCode inside {HS_ACK, HS_NAK, HS_STALL})
        else $error("illegal handshake code");
    AST_TOK_PULSE: assert property (tokValid |=> !tokValid)
        else $error("token longer than one cycle");
    AST_END_PULSE: assert property (pktEnd |=> !pktEnd)
        else $error("packet end longer than one cycle");
    AST_EXCLUSIVE: assert property (!(tokValid && (dataValid || pktEnd)))
        else $error("token overlaps data or packet end");
    AST_TOK_EP: assert property (tokValid |-> tokEp inside {[1:3]})
        else $error("token for an endpoint outside one to three");
    AST_QUIET_AFTER_END: assert property (pktEnd |=> quiet_s)
        else $error("next token before the handshake slot");
endmodule : usb_out_link_monitor

`default_nettype wire

// ---- verilog/usb_out_endpoint_control.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "usb_out_map.svh"

module usb_out_endpoint_control
    import usb_out_pkg::*;
#(
    parameter int MAX_PKT = 64
) (
    input  wire logic        clock,
    input  wire logic        rst,
    usb_out_link_if.dev      link,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq
);
    localparam int MEM_DEPTH = 6 * MAX_PKT;
    localparam int AW        = $clog2(MEM_DEPTH);

    dev_state_t s;
    dev_state_t n;
    logic [7:0]    mem [0:MEM_DEPTH-1];
    logic          memWe;
    logic [AW-1:0] memWAddr;
    logic [AW-1:0] memRAddr;
    logic [7:0]    memRData;
    logic [1:0]    se;
    logic [1:0]    re;
    logic [5:0]    idx;
    logic [7:0]    wd;
    logic          accept;
    logic          store;
    logic [2:0]    evt;
    ep_t           q;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [1:0] capOf(input ep_t p);
        return p.dbuf ? 2'h2 : 2'h1;
    endfunction : capOf

    // drop the head packet; the next one, if any, becomes current at once
    function automatic ep_t popPkt(input ep_t p);
        ep_t r;
        r = p;
        if (r.pktCount != 2'h0) begin
            r.pktCount = r.pktCount - 2'h1;
            r.rdSlot   = ~r.rdSlot;
        end
        r.rdPtr   = 10'h000;
        r.opReady = (r.pktCount != 2'h0);
        r.data_error_flag_alt = r.opReady & r.errSlot[r.rdSlot];
        return r;
    endfunction : popPkt

    assign se       = s.sel - 2'h1;
    assign idx      = avs_address[7:2];
    assign wd       = avs_writedata[7:0];
    assign accept   = ~s.waitReq & (avs_read | avs_write);
    assign memWAddr = AW'((32'(s.rxEp) * 2 + 32'(s.ep[s.rxEp].wrSlot)) * MAX_PKT + 32'(s.wrPtr));
    assign memRAddr = AW'((32'(se) * 2 + 32'(s.ep[se].rdSlot)) * MAX_PKT + 32'(s.ep[se].rdPtr));
    assign memRData = mem[memRAddr];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n         = s;
        evt       = 3'h0;
        memWe     = 1'b0;
        store     = 1'b0;
        re        = 2'h0;
        q         = s.ep[s.rxEp];
        n.hsValid = 1'b0;
        // one wait cycle per access; the effect lands on the edge with waitrequest low
        n.waitReq = ~(s.waitReq & (avs_read | avs_write));

        if (accept && avs_write) begin
            case (idx)
                `IDX_CTRL_STATUS: begin
                    if (wd[`CLEAR_TOGGLE_BIT]) begin
                        n.ep[se].toggle = 1'b0;
                    end
                    n.ep[se].sendStall = wd[`SEND_STALL_BIT];
                    if (!wd[`SENT_STALL_BIT]) begin
                        n.ep[se].sentStall = 1'b0;
                    end
                    if (!wd[`OVERRUN_BIT]) begin
                        n.ep[se].overrun = 1'b0;
                    end
                    if ((s.ep[se].opReady && !wd[`OUT_PKT_READY_BIT])
                        || (wd[`FLUSH_BIT] && s.ep[se].pktCount != 2'h0)) begin
                        n.ep[se] = popPkt(n.ep[se]);
                        evt[se]  = n.ep[se].opReady;
                    end
                end
                `IDX_CONFIG: begin
                    n.ep[se].dbuf = wd[`DBUF_BIT];
                    n.ep[se].iso  = wd[`ISO_BIT];
                end
                `IDX_SELECT: begin
                    if (wd[1:0] != 2'h0) begin
                        n.sel = wd[1:0];
                    end
                end
                `IDX_INT_STATUS: n.intStatus = s.intStatus & ~wd[2:0];
                `IDX_INT_MASK:   n.intMask   = wd[2:0];
                default: ;
            endcase
        end

        // fifo data pops one byte per accepted read
        if (accept && avs_read && idx == `IDX_FIFO_DATA && s.ep[se].opReady
            && s.ep[se].rdPtr != `PTR_MAX) begin
            n.ep[se].rdPtr = s.ep[se].rdPtr + 10'h001;
        end

        if (s.waitReq && avs_read) begin
            case (idx)
                `IDX_CTRL_STATUS: n.readData = {24'h00_0000, 1'b0, s.ep[se].sentStall,
                    s.ep[se].sendStall, 1'b0, s.ep[se].data_error_flag_alt, s.ep[se].overrun,
                    s.ep[se].pktCount == capOf(s.ep[se]), s.ep[se].opReady};
                `IDX_CONFIG:     n.readData = {24'h00_0000, s.ep[se].dbuf, s.ep[se].iso, 6'h00};
                `IDX_COUNT_LOW:  n.readData = {24'h00_0000, s.ep[se].count[s.ep[se].rdSlot][7:0]};
                `IDX_COUNT_HIGH: n.readData = {30'h0000_0000, s.ep[se].count[s.ep[se].rdSlot][9:8]};
                `IDX_SELECT:     n.readData = {30'h0000_0000, s.sel};
                `IDX_INT_STATUS: n.readData = {29'h0000_0000, s.intStatus};
                `IDX_INT_MASK:   n.readData = {29'h0000_0000, s.intMask};
                `IDX_FIFO_DATA:  n.readData = {24'h00_0000, memRData};
                default:         n.readData = 32'h0000_0000;
            endcase
        end

        // ----------------------------------------
        // receive side of the link
        // ----------------------------------------
        case (s.rx)
            RX_IDLE: begin
                if (link.tokValid && link.tokEp >= `FIRST_EP && link.tokEp <= `LAST_EP) begin
                    re      = link.tokEp[1:0] - 2'h1;
                    n.rxEp  = re;
                    n.rxPid = link.tokPid;
                    n.wrPtr = 10'h000;
                    if (!n.ep[re].iso && n.ep[re].sendStall) begin
                        n.rx = RX_STALL;
                    end else if (n.ep[re].pktCount >= capOf(n.ep[re])) begin
                        n.rx = RX_FULL;
                    end else begin
                        n.rx = RX_STORE;
                    end
                end
            end
            RX_STORE: begin
                if (link.dataValid) begin
                    // bytes past the buffer size are counted but not kept
                    memWe = (32'(s.wrPtr) < MAX_PKT);
                    if (s.wrPtr != `PTR_MAX) begin
                        n.wrPtr = s.wrPtr + 10'h001;
                    end
                end
                if (link.pktEnd) begin
                    n.rx = RX_IDLE;
                    q    = n.ep[s.rxEp];
                    if (!q.iso && !link.crcErr) begin
                        n.hsValid = 1'b1;
                        n.hsCode  = HS_ACK;
                    end
                    // a repeated bulk packet (toggle mismatch) is acked but dropped
                    store = q.iso | (~link.crcErr & (s.rxPid == q.toggle));
                    if (store) begin
                        q.count[q.wrSlot]   = s.wrPtr;
                        q.errSlot[q.wrSlot] = q.iso & link.crcErr;
                        q.wrSlot            = ~q.wrSlot;
                        q.pktCount          = q.pktCount + 2'h1;
                        if (!q.iso) begin
                            q.toggle = ~q.toggle;
                        end
                        if (!q.opReady) begin
                            q.opReady   = 1'b1;
                            q.data_error_flag_alt   = q.errSlot[q.rdSlot];
                            evt[s.rxEp] = 1'b1;
                        end
                        n.ep[s.rxEp] = q;
                    end
                end
            end
            RX_STALL: begin
                if (link.pktEnd) begin
                    n.rx = RX_IDLE;
                    if (!link.crcErr) begin
                        n.hsValid                  = 1'b1;
                        n.hsCode                   = HS_STALL;
                        n.ep[s.rxEp].sentStall     = 1'b1;
                        evt[s.rxEp]                = 1'b1;
                    end
                end
            end
            RX_FULL: begin
                if (link.pktEnd) begin
                    n.rx = RX_IDLE;
                    if (n.ep[s.rxEp].iso) begin
                        n.ep[s.rxEp].overrun = 1'b1;
                        evt[s.rxEp]          = 1'b1;
                    end else if (!link.crcErr) begin
                        n.hsValid = 1'b1;
                        n.hsCode  = HS_NAK;
                    end
                end
            end
            default: n.rx = RX_IDLE;
        endcase

        // a new event beats a clear in the same cycle
        n.intStatus = n.intStatus | evt;
        n.irq       = |(n.intStatus & n.intMask);
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s         <= '0;
            s.waitReq <= 1'b1;
            s.sel     <= `SELECT_RESET;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge clock) begin
        if (memWe) begin
            mem[memWAddr] <= link.dataByte;
        end
    end

    assign avs_readdata    = s.readData;
    assign avs_waitrequest = s.waitReq;
    assign irq             = s.irq;
    assign link.hsValid    = s.hsValid;
    assign link.hsCode     = s.hsCode;
endmodule : usb_out_endpoint_control

`default_nettype wire

// ---- verilog/usb_out_host_end.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "usb_out_map.svh"

module usb_out_host_end
    import usb_out_pkg::*;
#(
    parameter int unsigned FRAME_CYCLES = `FRAME_NS / `CLK_NS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    usb_out_link_if.hostEnd  link,
    input  wire logic [7:0]  avs_address,
    input  wire logic [31:0] avs_writedata,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    host_state_t s;
    host_state_t n;
    logic [5:0]  idx;
    logic        accept;
    logic        frameTick;

    assign idx       = avs_address[7:2];
    assign accept    = ~s.waitReq & (avs_read | avs_write);
    assign frameTick = (s.frameCnt == 32'h0000_0000);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n           = s;
        n.tokValid  = 1'b0;
        n.dataValid = 1'b0;
        n.pktEnd    = 1'b0;
        n.crcErr    = 1'b0;
        n.waitReq   = ~(s.waitReq & (avs_read | avs_write));
        n.frameCnt  = frameTick ? 32'(FRAME_CYCLES - 1) : s.frameCnt - 32'h0000_0001;

        if (accept && avs_write) begin
            case (idx)
                `HIDX_CMD: begin
                    // a command while busy is dropped; poll busy first
                    if (!s.busy) begin
                        n.ep     = avs_writedata[1:0];
                        n.pid    = avs_writedata[`HCMD_PID_BIT];
                        n.crc    = avs_writedata[`HCMD_CRC_BIT];
                        n.iso    = avs_writedata[`HCMD_ISO_BIT];
                        n.busy   = 1'b1;
                        n.hsSeen = 1'b0;
                        n.st     = avs_writedata[`HCMD_ISO_BIT] ? H_FRAME : H_TOKEN;
                    end
                end
                `HIDX_LEN:  n.len  = avs_writedata[9:0];
                `HIDX_SEED: n.seed = avs_writedata[7:0];
                default: ;
            endcase
        end

        if (s.waitReq && avs_read) begin
            case (idx)
                `HIDX_STATUS: n.readData = {28'h000_0000, s.hsCode, s.hsSeen, s.busy};
                `HIDX_LEN:    n.readData = {22'h00_0000, s.len};
                `HIDX_SEED:   n.readData = {24'h00_0000, s.seed};
                default:      n.readData = 32'h0000_0000;
            endcase
        end

        case (s.st)
            H_IDLE: ;
            H_FRAME: begin
                if (frameTick) begin
                    n.st = H_TOKEN;
                end
            end
            H_TOKEN: begin
                n.tokValid = 1'b1;
                n.tokEp    = {2'b00, s.ep};
                n.tokPid   = s.pid;
                n.cnt      = 10'h000;
                n.st       = H_DATA;
            end
            H_DATA: begin
                if (s.cnt != s.len) begin
                    n.dataValid = 1'b1;
                    n.dataByte  = s.seed + s.cnt[7:0];
                    n.cnt       = s.cnt + 10'h001;
                end else begin
                    n.pktEnd  = 1'b1;
                    n.crcErr  = s.crc;
                    n.waitCnt = 3'h0;
                    n.st      = H_WAIT;
                end
            end
            H_WAIT: begin
                if (link.hsValid) begin
                    n.hsSeen = 1'b1;
                    n.hsCode = link.hsCode;
                    n.busy   = 1'b0;
                    n.st     = H_IDLE;
                end else if (s.waitCnt == `HS_WAIT_CYCLES) begin
                    n.busy = 1'b0;
                    n.st   = H_IDLE;
                end else begin
                    n.waitCnt = s.waitCnt + 3'h1;
                end
            end
            default: n.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s         <= '0;
            s.waitReq <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign avs_readdata    = s.readData;
    assign avs_waitrequest = s.waitReq;
    assign link.tokValid   = s.tokValid;
    assign link.tokEp      = s.tokEp;
    assign link.tokPid     = s.tokPid;
    assign link.dataValid  = s.dataValid;
    assign link.dataByte   = s.dataByte;
    assign link.pktEnd     = s.pktEnd;
    assign link.crcErr     = s.crcErr;
endmodule : usb_out_host_end

`default_nettype wire

// ---- verilog/usb_out_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface usb_out_link_if;
    import usb_out_pkg::*;
    logic       tokValid;
    logic [3:0] tokEp;
    logic       tokPid;
    logic       dataValid;
    logic [7:0] dataByte;
    logic       pktEnd;
    logic       crcErr;
    logic       hsValid;
    hs_t        hsCode;

    modport dev (input tokValid, tokEp, tokPid, dataValid, dataByte, pktEnd, crcErr,
                 output hsValid, hsCode);
    modport hostEnd (output tokValid, tokEp, tokPid, dataValid, dataByte, pktEnd, crcErr,
                     input hsValid, hsCode);
endinterface : usb_out_link_if

`default_nettype wire

// ---- verilog/usb_out_map.svh ----
`ifndef USB_OUT_MAP_SVH
`define USB_OUT_MAP_SVH

// ----------------------------------------
// register indices, byte address = 4 * index
// ----------------------------------------
`define IDX_CTRL_STATUS  6'h14
`define IDX_CONFIG       6'h15
`define IDX_COUNT_LOW    6'h16
`define IDX_COUNT_HIGH   6'h17
`define IDX_SELECT       6'h0e
`define IDX_INT_STATUS   6'h02
`define IDX_INT_MASK     6'h03
`define IDX_FIFO_DATA    6'h20
`define HIDX_CMD         6'h00
`define HIDX_LEN         6'h01
`define HIDX_SEED        6'h02
`define HIDX_STATUS      6'h03

// ----------------------------------------
// field positions
// ----------------------------------------
`define OUT_PKT_READY_BIT 0
`define FIFO_FULL_BIT     1
`define OVERRUN_BIT       2
`define DATA_ERR_BIT      3
`define FLUSH_BIT         4
`define SEND_STALL_BIT    5
`define SENT_STALL_BIT    6
`define CLEAR_TOGGLE_BIT  7
`define ISO_BIT           6
`define DBUF_BIT          7
`define HCMD_PID_BIT      2
`define HCMD_CRC_BIT      3
`define HCMD_ISO_BIT      4

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SELECT_RESET     2'h1
`define FIRST_EP         4'h1
`define LAST_EP          4'h3
`define PTR_MAX          10'h3ff

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_NS           40
`define FRAME_NS         1000000
`define HS_WAIT_CYCLES   3'h4

`endif

// ---- verilog/usb_out_pkg.sv ----
`default_nettype none

package usb_out_pkg;
    typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hs_t;
    typedef enum logic [1:0] {RX_IDLE, RX_STORE, RX_STALL, RX_FULL} rx_t;
    typedef enum logic [2:0] {H_IDLE, H_FRAME, H_TOKEN, H_DATA, H_WAIT} host_st_t;

    typedef struct packed {
        logic             dbuf;
        logic             iso;
        logic             sendStall;
        logic             sentStall;
        logic             overrun;
        logic             data_error_flag_alt;
        logic             opReady;
        logic             toggle;
        logic [1:0]       pktCount;
        logic             rdSlot;
        logic             wrSlot;
        logic [9:0]       rdPtr;
        logic [1:0][9:0]  count;
        logic [1:0]       errSlot;
    } ep_t;

    typedef struct packed {
        ep_t [2:0]   ep;
        rx_t         rx;
        logic [1:0]  rxEp;
        logic        rxPid;
        logic [9:0]  wrPtr;
        logic [1:0]  sel;
        logic [2:0]  intStatus;
        logic [2:0]  intMask;
        logic        irq;
        logic        hsValid;
        hs_t         hsCode;
        logic        waitReq;
        logic [31:0] readData;
    } dev_state_t;

    typedef struct packed {
        host_st_t    st;
        logic [1:0]  ep;
        logic        pid;
        logic        crc;
        logic        iso;
        logic [9:0]  len;
        logic [7:0]  seed;
        logic [9:0]  cnt;
        logic [2:0]  waitCnt;
        logic [31:0] frameCnt;
        logic        busy;
        logic        hsSeen;
        hs_t         hsCode;
        logic        tokValid;
        logic [3:0]  tokEp;
        logic        tokPid;
        logic        dataValid;
        logic [7:0]  dataByte;
        logic        pktEnd;
        logic        crcErr;
        logic        waitReq;
        logic [31:0] readData;
    } host_state_t;
endpackage : usb_out_pkg

`default_nettype wire
